// ==== core/scit_top.sv ====
// Calibrated slow-oscillator interval timer with APB registers.
// Oscillator and pin inputs are sampled as synchronous to clk_in.
`timescale 1ns/1ps
`include "scit_defs.svh"

module scit_top #(
  parameter int SETTLE_CYC = `SCIT_SETTLE_US * `SCIT_CLK_MHZ,
  parameter int CAP_W      = 11
) (
  // Clock and reset
  input  wire logic        clk_in,
  input  wire logic        arst_n_in,
  // APB slave
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [7:0]  paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic      [31:0] prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  // Oscillators
  input  wire logic        fast_osc_clock_in,
  input  wire logic        slow_osc_clock_in,
  // Analog converter
  input  wire logic [15:0] adc_result_in,
  output logic             adc_start_out,
  output logic      [3:0]  analog_channel_sel_out,
  // Pins and system
  input  wire logic        switch_port_pin_in,
  output logic             buzzer_clock_output_out,
  output logic             low_power_out,
  output logic             irq_out
);

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  localparam int CONV_CYC = `SCIT_CONV_CYC;

  scit_pkg::scit_state_e state_q;
  logic                  en_q;
  logic [`SCIT_EV_W-1:0] ist_q;
  logic [`SCIT_EV_W-1:0] imsk_q;
  logic [`SCIT_EV_W-1:0] ev;
  logic [`SCIT_EV_W-1:0] w1c;
  logic                  slow_q;
  logic                  slow_prev_q;
  logic                  fast_q;
  logic                  fast_prev_q;
  logic                  sw_q;
  logic                  sw_prev_q;
  logic                  slow_fall;
  logic                  fast_rise;
  logic                  sw_fall;
  logic                  cap_run_q;
  logic                  cap_seen_q;
  logic [CAP_W-1:0]      cap_cnt_q;
  logic [CAP_W-1:0]      cap_val_q;
  logic [CAP_W-1:0]      period;
  logic                  per_ok;
  logic [`SCIT_DVD_W-1:0] dvd_q;
  logic [`SCIT_DVD_W-1:0] quot_q;
  logic [CAP_W-1:0]      rem_q;
  logic [CAP_W:0]        rem_sh;
  logic [4:0]            div_n_q;
  logic [15:0]           cmp_q;
  logic                  int_run_q;
  logic [2:0]            pre_q;
  logic [15:0]           int_cnt_q;
  logic                  tick;
  logic                  match;
  int unsigned           wait_q;
  logic [15:0]           res_q;
  logic                  buz_en_q;
  logic                  sw_en_q;
  logic [1:0]            buz_div_q;
  logic                  wr;
  logic                  rd;
  logic                  hit;

  // ----------------------------------------
  // Input sampling and edge detection
  // ----------------------------------------
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      slow_q      <= 1'b0;
      slow_prev_q <= 1'b0;
      fast_q      <= 1'b0;
      fast_prev_q <= 1'b0;
      sw_q        <= 1'b1;
      sw_prev_q   <= 1'b1;
    end
    else
    begin
      slow_q      <= slow_osc_clock_in;
      slow_prev_q <= slow_q;
      fast_q      <= fast_osc_clock_in;
      fast_prev_q <= fast_q;
      sw_q        <= switch_port_pin_in;
      sw_prev_q   <= sw_q;
    end
  end

  assign slow_fall = slow_prev_q & ~slow_q; // [R2]
  assign fast_rise = fast_q & ~fast_prev_q; // [R1]
  assign sw_fall   = sw_prev_q & ~sw_q;     // [R13]

  // ----------------------------------------
  // APB slave
  // ----------------------------------------
  // One wait state so read data can come from a flop
  assign wr  = psel_in & penable_in & pready_out & pwrite_in;
  assign rd  = psel_in & penable_in & ~pready_out & ~pwrite_in;
  assign hit = (paddr_in <= `SCIT_OFS_IRQ_MSK) && (paddr_in[1:0] == 2'b00);
  assign w1c = (wr && paddr_in == `SCIT_OFS_IRQ_ST) ? pwdata_in[`SCIT_EV_W-1:0] : '0;

  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out  <= 32'h00000000;
    end
    else
    begin
      pready_out  <= psel_in & penable_in & ~pready_out;
      pslverr_out <= psel_in & penable_in & ~pready_out & ~hit;
      prdata_out  <= 32'h00000000;
      if (rd)
      begin
        case (paddr_in)
          `SCIT_OFS_CTRL:    prdata_out <= {31'h0, en_q};
          `SCIT_OFS_STATUS:  prdata_out <= {24'h0, buz_en_q, int_run_q, cap_run_q, low_power_out, state_q};
          `SCIT_OFS_CAPTURE: prdata_out <= {{(32-CAP_W){1'b0}}, cap_val_q};
          `SCIT_OFS_COMPARE: prdata_out <= {16'h0, cmp_q};
          `SCIT_OFS_RESULT:  prdata_out <= {16'h0, res_q};
          `SCIT_OFS_IRQ_ST:  prdata_out <= {{(32-`SCIT_EV_W){1'b0}}, ist_q};
          `SCIT_OFS_IRQ_MSK: prdata_out <= {{(32-`SCIT_EV_W){1'b0}}, imsk_q};
          default:           prdata_out <= 32'h00000000;
        endcase
      end
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      en_q   <= 1'b0;
      imsk_q <= '0;
    end
    else if (wr && paddr_in == `SCIT_OFS_CTRL)
      en_q <= pwdata_in[`SCIT_CTRL_EN];
    else if (wr && paddr_in == `SCIT_OFS_IRQ_MSK)
      imsk_q <= pwdata_in[`SCIT_EV_W-1:0];
  end

  // ----------------------------------------
  // Interrupts
  // ----------------------------------------
  // A new event beats a clear in the same cycle
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      ist_q  <= '0;
      irq_out <= 1'b0;
    end
    else
    begin
      ist_q  <= (ist_q & ~w1c) | ev;
      irq_out <= |(ist_q & imsk_q);
    end
  end

  AST_IRQ_LEVEL: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    ##1 (irq_out == $past(|(ist_q & imsk_q))))
    else $error("irq level does not follow masked status");

  // ----------------------------------------
  // Period measurement
  // ----------------------------------------
  assign period = cap_cnt_q + 1'b1;                          // [R3]
  assign per_ok = (period >= `SCIT_PER_MIN) && (period <= `SCIT_PER_MAX); // [R16]

  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      cap_cnt_q  <= '0;
      cap_val_q  <= '0;
      cap_seen_q <= 1'b0;
    end
    else if (!cap_run_q)
    begin
      cap_cnt_q  <= '0;
      cap_seen_q <= 1'b0;
    end
    else if (slow_fall)                                      // [R2]
    begin
      cap_cnt_q  <= '0;
      cap_seen_q <= 1'b1;
      if (cap_seen_q && state_q == scit_pkg::ST_MEAS)        // [R4]
        cap_val_q <= cap_cnt_q;
    end
    else if (fast_rise && cap_cnt_q != '1)
      cap_cnt_q <= cap_cnt_q + 1'b1;                         // [R1]
  end

  AST_CAP_SECOND: assert property (@(posedge clk_in) disable iff (!arst_n_in) // [R4]
    $changed(cap_val_q) |-> $past(cap_seen_q) && $past(slow_fall))
    else $error("capture kept without a prior discarded capture");

  // ----------------------------------------
  // Compare divider
  // ----------------------------------------
  // Restoring divide, one quotient bit a cycle; 25 cycles per calibration
  assign rem_sh = {rem_q, dvd_q[`SCIT_DVD_W-1]};

  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      dvd_q   <= '0;
      quot_q  <= '0;
      rem_q   <= '0;
      div_n_q <= 5'h00;
    end
    else if (state_q != scit_pkg::ST_DIV)
    begin
      dvd_q   <= `SCIT_DIVIDEND;                             // [R17]
      quot_q  <= '0;
      rem_q   <= '0;
      div_n_q <= 5'h00;
    end
    else
    begin
      dvd_q   <= {dvd_q[`SCIT_DVD_W-2:0], 1'b0};
      div_n_q <= div_n_q + 5'h01;
      if (rem_sh >= {1'b0, cap_val_q + 1'b1})                // [R18]
      begin
        rem_q  <= CAP_W'(rem_sh - {1'b0, cap_val_q + 1'b1});
        quot_q <= {quot_q[`SCIT_DVD_W-2:0], 1'b1};
      end
      else
      begin
        rem_q  <= rem_sh[CAP_W-1:0];
        quot_q <= {quot_q[`SCIT_DVD_W-2:0], 1'b0};
      end
    end
  end

  // ----------------------------------------
  // Interval counter
  // ----------------------------------------
  assign tick  = int_run_q && slow_fall && pre_q == `SCIT_PRE_LAST; // [R6]
  assign match = tick && int_cnt_q == cmp_q;                 // [R5]

  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      cmp_q <= `SCIT_CMP_RST;                                // [R7]
    else if (state_q == scit_pkg::ST_LOAD)
      cmp_q <= quot_q[15:0] - 16'h0001;                      // [R17]
  end

  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      pre_q     <= 3'h0;
      int_cnt_q <= 16'h0000;
    end
    else if (state_q == scit_pkg::ST_START)
    begin
      pre_q     <= 3'h0;
      int_cnt_q <= 16'h0000;
    end
    else if (int_run_q && slow_fall)
    begin
      pre_q <= pre_q + 3'h1;
      if (match)
        int_cnt_q <= 16'h0000;
      else if (tick)
        int_cnt_q <= int_cnt_q + 16'h0001;
    end
  end

  AST_TICK_ONLY: assert property (@(posedge clk_in) disable iff (!arst_n_in) // [R6]
    $changed(int_cnt_q) |-> $past(tick) || $past(state_q == scit_pkg::ST_START))
    else $error("interval count moved without a divided tick");

  AST_MATCH_WRAP: assert property (@(posedge clk_in) disable iff (!arst_n_in) // [R5]
    match |=> int_cnt_q == 16'h0000)
    else $error("interval count not cleared on match");

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      state_q   <= scit_pkg::ST_IDLE;
      wait_q    <= 0;
      cap_run_q <= 1'b0;
      int_run_q <= 1'b0;
      res_q     <= 16'h0000;
      buz_en_q  <= 1'b0;
      sw_en_q   <= 1'b0;
    end
    else if (!en_q)
    begin
      state_q   <= scit_pkg::ST_IDLE;
      cap_run_q <= 1'b0;
      int_run_q <= 1'b0;
      buz_en_q  <= 1'b0;
      sw_en_q   <= 1'b0;
    end
    else
    begin
      wait_q <= wait_q + 1;
      case (state_q)
        scit_pkg::ST_IDLE:
        begin
          wait_q  <= 0;
          state_q <= scit_pkg::ST_SETTLE;
        end
        scit_pkg::ST_SETTLE:
          if (wait_q >= SETTLE_CYC - 1)                      // [R8]
          begin
            cap_run_q <= 1'b1;
            state_q   <= scit_pkg::ST_MEAS;
          end
        scit_pkg::ST_MEAS:
          if (slow_fall && cap_seen_q)                       // [R4]
          begin
            if (per_ok)
              state_q <= scit_pkg::ST_DIV;
            else
              cap_run_q <= 1'b0;                             // [R16]
          end
          else if (!cap_run_q)
            cap_run_q <= 1'b1;
        scit_pkg::ST_DIV:
          if (div_n_q == 5'(`SCIT_DVD_W - 1))
            state_q <= scit_pkg::ST_LOAD;
        scit_pkg::ST_LOAD:
          state_q <= scit_pkg::ST_CAPSTOP;                   // [R9]
        scit_pkg::ST_CAPSTOP:
        begin
          cap_run_q <= 1'b0;                                 // [R9]
          state_q   <= scit_pkg::ST_START;
        end
        scit_pkg::ST_START:
        begin
          int_run_q <= 1'b1;                                 // [R15]
          state_q   <= scit_pkg::ST_SLEEP;
        end
        scit_pkg::ST_SLEEP:
          if (match)                                         // [R10]
          begin
            wait_q  <= 0;
            state_q <= scit_pkg::ST_CONV;
          end
        scit_pkg::ST_CONV:
          if (wait_q >= CONV_CYC - 1)                        // [R11]
          begin
            res_q <= adc_result_in;
            if (adc_result_in >= `SCIT_THRESH)               // [R12]
            begin
              buz_en_q  <= 1'b1;
              int_run_q <= 1'b0;
              sw_en_q   <= 1'b1;
              state_q   <= scit_pkg::ST_ALARM;
            end
            else
              state_q <= scit_pkg::ST_MEAS;                  // [R15]
            cap_run_q <= adc_result_in < `SCIT_THRESH;
          end
        scit_pkg::ST_ALARM:
          if (sw_en_q && sw_fall)                            // [R13]
          begin
            buz_en_q  <= 1'b0;
            sw_en_q   <= 1'b0;
            cap_run_q <= 1'b1;
            state_q   <= scit_pkg::ST_MEAS;                  // [R15]
          end
        default:
          state_q <= scit_pkg::ST_IDLE;
      endcase
    end
  end

  always_comb
  begin
    ev                  = '0;
    ev[`SCIT_EV_MATCH]  = match;
    ev[`SCIT_EV_CONV]   = state_q == scit_pkg::ST_CONV && wait_q >= CONV_CYC - 1 && en_q;
    ev[`SCIT_EV_ALARM]  = ev[`SCIT_EV_CONV] && adc_result_in >= `SCIT_THRESH;
    ev[`SCIT_EV_SWITCH] = state_q == scit_pkg::ST_ALARM && sw_en_q && sw_fall && en_q;
    ev[`SCIT_EV_RANGE]  = state_q == scit_pkg::ST_MEAS && slow_fall && cap_seen_q && !per_ok && en_q;
  end

  AST_SETTLE_WAIT: assert property (@(posedge clk_in) disable iff (!arst_n_in) // [R8]
    (state_q == scit_pkg::ST_SETTLE) ##1 (state_q == scit_pkg::ST_MEAS) |-> $past(wait_q) >= SETTLE_CYC - 1)
    else $error("measurement began before the settle time");

  AST_DIV_RANGE: assert property (@(posedge clk_in) disable iff (!arst_n_in) // [R16]
    state_q == scit_pkg::ST_DIV |-> (cap_val_q + 1'b1) >= `SCIT_PER_MIN && (cap_val_q + 1'b1) <= `SCIT_PER_MAX)
    else $error("divide started on an out-of-range period");

  AST_LOAD_ORDER: assert property (@(posedge clk_in) disable iff (!arst_n_in || !en_q) // [R9]
    state_q == scit_pkg::ST_LOAD |=> state_q == scit_pkg::ST_CAPSTOP ##1 !cap_run_q && !int_run_q ##1 int_run_q)
    else $error("load, capture stop and start out of order");

  AST_ALARM_SET: assert property (@(posedge clk_in) disable iff (!arst_n_in || !en_q) // [R12]
    ev[`SCIT_EV_ALARM] |=> buz_en_q && sw_en_q && !int_run_q)
    else $error("alarm did not enable buzzer and stop the counter");

  AST_SW_STOP: assert property (@(posedge clk_in) disable iff (!arst_n_in || !en_q) // [R13]
    ev[`SCIT_EV_SWITCH] |=> !buz_en_q ##2 !buzzer_clock_output_out)
    else $error("switch press did not stop the buzzer");

  // ----------------------------------------
  // Converter, buzzer and power outputs
  // ----------------------------------------
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      adc_start_out          <= 1'b0;
      analog_channel_sel_out <= `SCIT_ANA_CHAN;
      low_power_out          <= 1'b0;
    end
    else
    begin
      adc_start_out          <= match && state_q == scit_pkg::ST_SLEEP && en_q; // [R10]
      analog_channel_sel_out <= `SCIT_ANA_CHAN;              // [R11]
      low_power_out          <= state_q == scit_pkg::ST_SLEEP && !match; // [R10]
    end
  end

  AST_ONE_SHOT: assert property (@(posedge clk_in) disable iff (!arst_n_in) // [R11]
    adc_start_out |=> !adc_start_out [*2])
    else $error("conversion start not a single pulse");

  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      buz_div_q               <= 2'h0;
      buzzer_clock_output_out <= 1'b0;
    end
    else
    begin
      if (slow_fall)
        buz_div_q <= buz_div_q + 2'h1;                       // [R14]
      buzzer_clock_output_out <= buz_en_q & buz_div_q[1];    // [R14]
    end
  end

  AST_BUZ_QUIET: assert property (@(posedge clk_in) disable iff (!arst_n_in) // [R14]
    !buz_en_q |=> !buzzer_clock_output_out)
    else $error("buzzer toggles while disabled");

endmodule // scit_top

// ==== core/scit_defs.svh ====
// Offsets, fields, reset values and timing for the calibrated interval timer.
// Assumes a 20 MHz system clock and an APB master with 32-bit data.
//
// Contract
// [R1] Capture counter counts 8 MHz fast oscillator
// [R2] Start and capture on slow clock falls
// [R3] Measured period equals captured value plus one
// [R4] Discard first capture, keep the second
// [R5] 16-bit interval counter matches compare value
// [R6] Interval counter ticks at slow clock over 8
// [R7] Compare starts at 0x927B before calibration
// [R8] Wait 210 us before measuring
// [R9] Load compare, stop capture, start interval
// [R10] Match wakes and starts one conversion
// [R11] One-shot software conversion, 6.75 us
// [R12] Result at threshold: buzzer, stop, enable switch
// [R13] Switch falling edge stops the buzzer
// [R14] Buzzer outputs slow clock over four
// [R15] Recalibrate, resume counter, back to sleep
// [R16] Accept periods 459 to 634 only
// [R17] Compare is 19987500 over period minus one
// [R18] Truncating unsigned divide, low 16 bits kept
`ifndef SCIT_DEFS_SVH
`define SCIT_DEFS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define SCIT_OFS_CTRL    8'h00
`define SCIT_OFS_STATUS  8'h04
`define SCIT_OFS_CAPTURE 8'h08
`define SCIT_OFS_COMPARE 8'h0C
`define SCIT_OFS_RESULT  8'h10
`define SCIT_OFS_IRQ_ST  8'h14
`define SCIT_OFS_IRQ_MSK 8'h18

// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define SCIT_CTRL_EN     0
`define SCIT_EV_MATCH    0
`define SCIT_EV_CONV     1
`define SCIT_EV_ALARM    2
`define SCIT_EV_SWITCH   3
`define SCIT_EV_RANGE    4
`define SCIT_EV_W        5
`define SCIT_CMP_RST     16'h927B
`define SCIT_THRESH      16'h0E00
`define SCIT_PER_MIN     11'd459
`define SCIT_PER_MAX     11'd634
`define SCIT_DIVIDEND    25'd19987500
`define SCIT_DVD_W       25
`define SCIT_ANA_CHAN    4'h2
`define SCIT_PRE_LAST    3'h7

// ----------------------------------------
// Timing
// ----------------------------------------
`define SCIT_CLK_MHZ     20
`define SCIT_SETTLE_US   210
`define SCIT_CONV_NS     6750
`define SCIT_CONV_CYC    ((`SCIT_CONV_NS * `SCIT_CLK_MHZ + 999) / 1000)

`endif

// ==== core/scit_pkg.sv ====
// Types shared by the calibrated interval timer.
// Assumes nothing of its surroundings.
package scit_pkg;

  typedef enum logic [3:0] {
    ST_IDLE, ST_SETTLE, ST_MEAS, ST_DIV, ST_LOAD,
    ST_CAPSTOP, ST_START, ST_SLEEP, ST_CONV, ST_ALARM
  } scit_state_e;

endpackage

// ==== verification/scit_partner.sv ====
// Far-side model of the timer: fast and slow oscillators, converter result and switch.
// Assumes clk_in at 20 MHz; both oscillator outputs step on its rising edge.
`timescale 1ns/1ps

module scit_partner (
  // Clock and bench control
  input  wire logic        clk_in,
  input  wire logic [31:0] period_in,
  input  wire logic [15:0] adc_level_in,
  // Towards the timer
  output logic             fast_osc_out,
  output logic             slow_osc_out,
  output logic      [15:0] adc_result_out,
  output logic             switch_pin_out
);
  int   slow_cnt;
  int   slow_len;
  logic fast_ph;

  // ------------------------------------------
  // Oscillators
  // ------------------------------------------
  // The fast clock is scaled to 2-cycle levels, which the sampled edge
  // detector needs; periods are then whole counts of 4-cycle units.
  // Fast rises share a cycle with slow falls, as a counter clocked by the
  // fast clock would see them, so a span of n fast periods captures n-1.
  initial
  begin
    fast_ph      = 1'b1;
    fast_osc_out = 1'b0;
    slow_osc_out = 1'b0;
    slow_cnt     = 0;
    slow_len     = 533;
  end

  always @(posedge clk_in)
  begin
    fast_ph <= ~fast_ph;
    if (fast_ph)
      fast_osc_out <= ~fast_osc_out;
    // A new length is taken only at a fall, so no span mixes two lengths
    if (slow_cnt >= 4 * slow_len - 1)
    begin
      slow_cnt <= 0;
      slow_len <= period_in;
    end
    else
      slow_cnt <= slow_cnt + 1;
    slow_osc_out <= (slow_cnt >= 2 * slow_len);
  end

  // ------------------------------------------
  // Converter and switch
  // ------------------------------------------
  // Switch released: the pulled-up line idles high, a press pulls it low
  assign switch_pin_out = 1'b1;
  assign adc_result_out = adc_level_in;
endmodule // scit_partner

// ==== verification/slow_osc_calibrated_interval_timer_test.sv ====
// Self-checking bench for the calibrated interval timer: APB, calibration, range events, interrupt.
// Assumes scit_partner as far side; a full 20 s interval is far too long to reach in simulation.
`timescale 1ns/1ps
`include "scit_defs.svh"

module slow_osc_calibrated_interval_timer_test;
  logic        clk_in;
  logic        arst_n_in;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        fast_osc;
  logic        slow_osc;
  logic [15:0] adc_result;
  logic        adc_start;
  logic [3:0]  chan_sel;
  logic        switch_pin;
  logic        buzzer;
  logic        low_power;
  logic        irq;
  int          period;
  int          err_total;
  int          check_count;
  int          cycles;
  logic [31:0] rdata;
  logic        rerr;

  scit_top #(.SETTLE_CYC(20)) scit_top_i (
    .clk_in(clk_in), .arst_n_in(arst_n_in), .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
    .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
    .fast_osc_clock_in(fast_osc), .slow_osc_clock_in(slow_osc), .adc_result_in(adc_result),
    .adc_start_out(adc_start), .analog_channel_sel_out(chan_sel), .switch_port_pin_in(switch_pin),
    .buzzer_clock_output_out(buzzer), .low_power_out(low_power), .irq_out(irq));

  scit_partner scit_partner_i (
    .clk_in(clk_in), .period_in(period), .adc_level_in(16'h0DFF), .fast_osc_out(fast_osc),
    .slow_osc_out(slow_osc), .adc_result_out(adc_result), .switch_pin_out(switch_pin));

  // ------------------------------------------
  // Clock, timeout and verdict
  // ------------------------------------------
  initial
  begin
    clk_in = 1'b0;
    forever #25 clk_in = ~clk_in;
  end

  always @(posedge clk_in)
  begin
    cycles++;
    if (cycles == 90000)
    begin
      err_total++;
      $display("[FAIL] %0t timeout", $time);
      results;
    end
  end

  task automatic results;
    if (err_total == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    check_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // ------------------------------------------
  // Bus helpers
  // ------------------------------------------
  // Starts on a fresh edge, so a release is never followed by a set in one step
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    @(posedge clk_in);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= wd;
    @(posedge clk_in);
    penable <= 1'b1;
    n = 0;
    // Only the bench timeout ends a wait that never sees ready
    do
    begin
      @(posedge clk_in);
      n++;
    end
    while (pready !== 1'b1);
    rdata = prdata;
    rerr  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    chk(32'(n), 32'h2, "wait states");
  endtask

  // Reads until the masked value matches or lim reads are spent
  task automatic poll(input logic [7:0] a, input logic [31:0] m, input logic [31:0] v, input int lim,
                      input string what);
    int k;
    k = 0;
    do
    begin
      apb(1'b0, a, 32'h0);
      k++;
    end
    while ((rdata & m) !== v && k < lim);
    chk(rdata & m, v, what);
  endtask

  // ------------------------------------------
  // Scenarios
  // ------------------------------------------
  task automatic t_reset;
    chk({28'h0, chan_sel}, 32'h2, "channel");
    chk({29'h0, buzzer, low_power, adc_start}, 32'h0, "idle pins");
    poll(`SCIT_OFS_COMPARE, 32'hFFFF_FFFF, 32'h927B, 1, "compare reset");
    poll(`SCIT_OFS_STATUS, 32'hFFFF_FFFF, 32'h0, 1, "status reset");
  endtask

  task automatic t_refuse;
    apb(1'b0, 8'h1C, 32'h0);
    chk({rerr, rdata[30:0]}, 32'h8000_0000, "unmapped");
    apb(1'b1, `SCIT_OFS_COMPARE, 32'h1234);
    poll(`SCIT_OFS_COMPARE, 32'hFFFF_FFFF, 32'h927B, 1, "read-only compare");
  endtask

  // Period p in fast counts; compare is the truncated quotient less one, low half kept
  task automatic t_cal(input int p);
    logic [31:0] cmp;
    cmp = 32'((32'h0130_FC2C / p - 1) & 32'h0000_FFFF);
    period <= p;
    apb(1'b1, `SCIT_OFS_CTRL, 32'h0);
    apb(1'b1, `SCIT_OFS_CTRL, 32'h1);
    poll(`SCIT_OFS_STATUS, 32'hF, 32'h1, 1, "settling");
    repeat (25) @(posedge clk_in);
    poll(`SCIT_OFS_STATUS, 32'hF, 32'h2, 1, "measuring");
    poll(`SCIT_OFS_STATUS, 32'hFF, 32'h57, 4000, "asleep");
    poll(`SCIT_OFS_CAPTURE, 32'hFFFF_FFFF, 32'(p - 1), 1, "capture");
    poll(`SCIT_OFS_COMPARE, 32'hFFFF_FFFF, cmp, 1, "compare");
    chk({29'h0, buzzer, low_power, adc_start}, 32'h2, "sleep pins");
  endtask

  task automatic t_range;
    apb(1'b1, `SCIT_OFS_IRQ_MSK, 32'h0);
    period <= 458;
    apb(1'b1, `SCIT_OFS_CTRL, 32'h0);
    apb(1'b1, `SCIT_OFS_CTRL, 32'h1);
    poll(`SCIT_OFS_IRQ_ST, 32'h10, 32'h10, 4000, "short period");
    chk({31'h0, irq}, 32'h0, "masked irq");
    apb(1'b1, `SCIT_OFS_IRQ_MSK, 32'h10);
    repeat (2) @(posedge clk_in);
    chk({31'h0, irq}, 32'h1, "unmasked irq");
    // Stopped first, so no fresh range event can race the clear
    apb(1'b1, `SCIT_OFS_CTRL, 32'h0);
    period <= 635;
    apb(1'b1, `SCIT_OFS_IRQ_ST, 32'h10);
    poll(`SCIT_OFS_IRQ_ST, 32'h10, 32'h0, 1, "cleared");
    chk({31'h0, irq}, 32'h0, "irq dropped");
    apb(1'b1, `SCIT_OFS_CTRL, 32'h1);
    poll(`SCIT_OFS_IRQ_ST, 32'h10, 32'h10, 4000, "long period");
    poll(`SCIT_OFS_STATUS, 32'hF, 32'h2, 1, "still measuring");
    apb(1'b1, `SCIT_OFS_CTRL, 32'h0);
    poll(`SCIT_OFS_STATUS, 32'hF, 32'h0, 1, "disabled");
    chk({31'h0, low_power}, 32'h0, "awake when off");
  endtask

  initial
  begin
    arst_n_in   = 1'b0;
    psel        = 1'b0;
    penable     = 1'b0;
    pwrite      = 1'b0;
    paddr       = 8'h00;
    pwdata      = 32'h0;
    period      = 533;
    err_total   = 0;
    check_count = 0;
    cycles      = 0;
    repeat (8) @(posedge clk_in);
    arst_n_in <= 1'b1;
    t_reset;
    t_refuse;
    t_cal(459);
    t_cal(634);
    t_range;
    results;
  end
endmodule // slow_osc_calibrated_interval_timer_test
